// file: core/ats_defines.vh
// Purpose: Constants of the transmit segmentation channel block.
// Assumes: Byte addresses on an 8-bit register port, 32-bit data.
// Notes: Included by every design file of the block.
`ifndef ATS_DEFINES_VH
`define ATS_DEFINES_VH

// ************************************************************
// Register byte addresses.
// ************************************************************
`define ATS_REG_CTRL 8'h00
`define ATS_REG_CFG 8'h04
`define ATS_REG_HDR 8'h08
`define ATS_REG_BASE 8'h0C
`define ATS_REG_PTR 8'h10
`define ATS_REG_CRC 8'h14
`define ATS_REG_PACK 8'h18
`define ATS_REG_RATE 8'h1C
`define ATS_REG_ISTAT 8'h20
`define ATS_REG_ICLR 8'h24
`define ATS_REG_IEN 8'h28
`define ATS_REG_EVT 8'h2C

// ************************************************************
// Field positions.
// ************************************************************
`define ATS_CTRL_EN 0
`define ATS_CTRL_MODEN 1
`define ATS_CTRL_BUFEVT 2
`define ATS_CFG_SUSP 0
`define ATS_CFG_ABR 1
`define ATS_CFG_DROP_LO 2
`define ATS_CFG_ENTRY_LO 4
`define ATS_CFG_OFS_LO 8
`define ATS_CFG_MOD_LO 24
`define ATS_EVT_MOD_LO 7
`define ATS_IRQ_CELL 0
`define ATS_IRQ_FRAME 1
`define ATS_IRQ_SUSP 2

// ************************************************************
// Reset values.
// ************************************************************
`define ATS_CTRL_RST 32'h00000000
`define ATS_CFG_RST 32'h00000000
`define ATS_PACK_RST 32'h01002F00
`define ATS_WPP_RST 8'h2F
`define ATS_PPF_RST 8'h01
`define ATS_CRC_INIT 32'hFFFFFFFF
`define ATS_CRC_POLY 32'h04C11DB7

// ************************************************************
// Cell types, chosen by the entry point, and payload sizes.
// ************************************************************
`define ATS_T_RAW48 3'h0
`define ATS_T_RAW52 3'h1
`define ATS_T_AAL5 3'h2
`define ATS_T_SW48 3'h3
`define ATS_T_SW54 3'h4
`define ATS_T_FRAME 3'h5
`define ATS_PAY48 6'h30
`define ATS_PAY52 6'h34
`define ATS_PAY54 6'h36
`define ATS_WORD_BYTES 6'h04

`endif

// file: core/ats_crc32.v
// Purpose: One 32-bit word step of the running frame CRC.
// Assumes: Most significant bit of the word enters first.
// Notes: Purely combinational; the caller holds the CRC in a register.
`timescale 1ns/10ps
`include "ats_defines.vh"

module ats_crc32 (
	// CRC so far and the new word.
	input wire [31:0] crc_in,
	input wire [31:0] data_in,
	// CRC after the word.
	output reg [31:0] crc_out
);

	integer i;

	// ************************************************************
	// Bitwise shift of the word through the polynomial.
	// ************************************************************

	// A loop keeps this readable; synthesis flattens it to XOR trees.
	always @* begin
		crc_out = crc_in;
		for (i = 31; i >= 0; i = i - 1) begin
			if (crc_out[31] ^ data_in[i]) begin
				crc_out = {crc_out[30:0], 1'b0} ^ `ATS_CRC_POLY;
			end else begin
				crc_out = {crc_out[30:0], 1'b0};
			end
		end
	end

endmodule

// file: core/ats_evt_fmt.v
// Purpose: Builds the transmit-complete event word.
// Assumes: go is a one-cycle pulse at frame close.
// Notes: The event leaves from flip-flops one cycle after go.
`timescale 1ns/10ps
`include "ats_defines.vh"

module ats_evt_fmt (
	// Clock and reset.
	input wire core_clk,
	input wire rst_n,
	// Request and its context.
	input wire go,
	input wire buf_evt,
	input wire mod_en,
	input wire [1:0] evt_mod,
	input wire [31:0] buf_addr,
	input wire [31:0] desc_addr,
	// Event out.
	output reg evt_valid_r,
	output reg [31:0] evt_word_r
);

	reg [31:0] word_nxt;

	// ************************************************************
	// Event word choice.
	// ************************************************************

	// The modifier only touches buffer address events.
	always @* begin
		word_nxt = desc_addr;
		if (buf_evt) begin
			word_nxt = buf_addr;
			if (mod_en) begin
				word_nxt[`ATS_EVT_MOD_LO+1:`ATS_EVT_MOD_LO] =
					buf_addr[`ATS_EVT_MOD_LO+1:`ATS_EVT_MOD_LO] | evt_mod; // RL4 RL5
			end
		end
	end

	// Output register; the word holds until the next event.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			evt_valid_r <= 1'b0;
			evt_word_r <= 32'h00000000;
		end else begin
			evt_valid_r <= go;
			if (go) begin
				evt_word_r <= word_nxt;
			end
		end
	end

endmodule

// file: core/ats_seg_channel.v
// Purpose: Transmit state of one segmentation channel descriptor.
// Assumes: One clock; the fetch side answers with fetch_ack.
// Notes: CRC covers whole words; a short last word enters whole, unused bytes included.
//
// Behaviour
// RL1: Suspend ABR cells while suspend bit set.
// RL2: Two-bit field picks one of four drops.
// RL3: Fetch starts at buffer plus data offset.
// RL4: Optionally OR modifier into event bits 8-7.
// RL5: Modifier only on buffer address events.
// RL6: Entry point loads both processor pointers.
// RL7: Entry point selects the generated cell type.
// RL8: Cell header comes from descriptor header bytes.
// RL9: Pointer set at frame queue, then advances.
// RL10: Running CRC updated per segmented word.
// RL11: Eight-bit word count for fixed-block types.
// RL12: Software sets words per packet.
// RL13: Eight-bit current packet index kept.
// RL14: Software sets packets per frame.
// RL15: Sixteen-bit explicit rate held per descriptor.
// RL16: Wrap word count, advance index, close frame.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "ats_defines.vh"

module ats_seg_channel #(
	parameter [31:0] DESC_ADDR = 32'h00000000
) (
	// Clock and reset.
	input wire core_clk,
	input wire rst_n,
	// Register port.
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Scheduler.
	input wire cell_opp,
	input wire frame_queue,
	// Cell generation.
	output reg cell_start,
	output reg [3:0] upd_ip,
	output reg [3:0] gen_ip,
	output reg [2:0] cell_type,
	output reg [31:0] cell_hdr,
	output reg [1:0] drop_sel,
	output wire [3:0] drop_en,
	output wire [15:0] abr_rate,
	// Data fetch.
	output wire fetch_req,
	output wire [31:0] fetch_addr,
	input wire fetch_ack,
	input wire [31:0] fetch_data,
	input wire fetch_last,
	// Payload out.
	output reg pay_valid,
	output reg [31:0] pay_data,
	output reg [2:0] pay_bytes,
	// Completion events and interrupt.
	output wire evt_valid,
	output wire [31:0] evt_word,
	output wire irq
);

	// ************************************************************
	// States and helpers.
	// ************************************************************
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_FETCH = 2'h1;
	localparam [1:0] ST_DONE = 2'h2;

	// Entry point to cell type; unknown entries fall back to raw 48.
	function [2:0] ats_type;
		input [3:0] entry;
		begin
			case (entry)
				4'h0: ats_type = `ATS_T_RAW48;
				4'h1: ats_type = `ATS_T_RAW52;
				4'h2: ats_type = `ATS_T_AAL5;
				4'h3: ats_type = `ATS_T_SW48;
				4'h4: ats_type = `ATS_T_SW54;
				4'h5: ats_type = `ATS_T_FRAME;
				default: ats_type = `ATS_T_RAW48;
			endcase
		end
	endfunction

	// Payload bytes of one cell of a given type.
	function [5:0] ats_pay;
		input [2:0] t;
		begin
			case (t)
				`ATS_T_RAW52: ats_pay = `ATS_PAY52;
				`ATS_T_SW54: ats_pay = `ATS_PAY54;
				default: ats_pay = `ATS_PAY48;
			endcase
		end
	endfunction

	// ************************************************************
	// Registers.
	// ************************************************************
	reg [31:0] ctrl_r; // Segmenter control.
	reg [31:0] cfg_r; // Suspend, ABR, drop, entry, offset, modifier.
	reg [31:0] hdr_r; // Cell header bytes.
	reg [31:0] base_r; // Buffer start address.
	reg [31:0] ptr_r; // Next data to send.
	reg [31:0] crc_r; // Running CRC.
	reg [7:0] wcnt_r; // Words of the current packet sent.
	reg [7:0] wpp_r; // Words per packet.
	reg [7:0] pidx_r; // Current packet index.
	reg [7:0] ppf_r; // Packets per frame.
	reg [15:0] rate_r; // Explicit rate.
	reg [2:0] ist_r; // Sticky interrupt status.
	reg [2:0] ien_r; // Interrupt enables.
	reg [1:0] st_r; // Engine state.
	reg [5:0] left_r; // Payload bytes left in this cell.
	reg close_r; // Frame ends with this cell.
	reg [7:0] wcnt_nxt;
	reg [7:0] pidx_nxt;
	reg close_nxt;
	reg [2:0] take;
	wire [31:0] crc_next;
	wire susp;
	wire ld_wr;
	wire is_frame;
	wire frame_go;

	assign susp = cfg_r[`ATS_CFG_SUSP] & cfg_r[`ATS_CFG_ABR];
	assign ld_wr = reg_wr & (reg_addr == `ATS_REG_PACK);
	assign is_frame = (cell_type == `ATS_T_FRAME);
	assign fetch_req = (st_r == ST_FETCH);
	assign fetch_addr = ptr_r;
	assign drop_en = 4'h1 << drop_sel; // RL2
	assign abr_rate = rate_r; // RL15
	assign irq = |(ist_r & ien_r);
	assign frame_go = (st_r == ST_DONE) & close_r;

	// ************************************************************
	// Sub-blocks.
	// ************************************************************
	ats_crc32 u_crc (
		.crc_in(crc_r),
		.data_in(fetch_data),
		.crc_out(crc_next)
	);

	ats_evt_fmt u_evt (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.go(frame_go),
		.buf_evt(ctrl_r[`ATS_CTRL_BUFEVT]),
		.mod_en(ctrl_r[`ATS_CTRL_MODEN]),
		.evt_mod(cfg_r[`ATS_CFG_MOD_LO+1:`ATS_CFG_MOD_LO]),
		.buf_addr(base_r),
		.desc_addr(DESC_ADDR),
		.evt_valid_r(evt_valid),
		.evt_word_r(evt_word)
	);

	// ************************************************************
	// Packing counters for the next accepted word.
	// ************************************************************

	// Only fixed-block cells count words; others end on fetch_last.
	always @* begin
		wcnt_nxt = wcnt_r;
		pidx_nxt = pidx_r;
		close_nxt = close_r | fetch_last;
		take = (left_r >= `ATS_WORD_BYTES) ? 3'h4 : left_r[2:0];
		if (is_frame) begin
			close_nxt = close_r;
			wcnt_nxt = wcnt_r + 8'h01; // RL11
			if (wcnt_nxt == wpp_r) begin
				wcnt_nxt = 8'h00; // RL16
				pidx_nxt = pidx_r + 8'h01; // RL13
				if (pidx_nxt == ppf_r) begin
					pidx_nxt = 8'h00; // RL16
					close_nxt = 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// Software registers.
	// ************************************************************

	// Config registers are plain storage written by software.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_r <= `ATS_CTRL_RST;
			cfg_r <= `ATS_CFG_RST;
			hdr_r <= 32'h00000000;
			base_r <= 32'h00000000;
			wpp_r <= `ATS_WPP_RST;
			ppf_r <= `ATS_PPF_RST;
			rate_r <= 16'h0000;
			ien_r <= 3'h0;
		end else if (reg_wr) begin
			case (reg_addr)
				`ATS_REG_CTRL: ctrl_r <= reg_wdata;
				`ATS_REG_CFG: cfg_r <= reg_wdata;
				`ATS_REG_HDR: hdr_r <= reg_wdata;
				`ATS_REG_BASE: base_r <= reg_wdata;
				`ATS_REG_RATE: rate_r <= reg_wdata[15:0];
				`ATS_REG_IEN: ien_r <= reg_wdata[2:0];
				`ATS_REG_PACK: begin
					wpp_r <= reg_wdata[15:8]; // RL12
					ppf_r <= reg_wdata[31:24]; // RL14
				end
				default: begin
				end
			endcase
		end
	end

	// Read data stand one cycle after the strobe; unmapped reads zero.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`ATS_REG_CTRL: reg_rdata <= ctrl_r;
				`ATS_REG_CFG: reg_rdata <= cfg_r;
				`ATS_REG_HDR: reg_rdata <= hdr_r;
				`ATS_REG_BASE: reg_rdata <= base_r;
				`ATS_REG_PTR: reg_rdata <= ptr_r;
				`ATS_REG_CRC: reg_rdata <= crc_r;
				`ATS_REG_PACK: reg_rdata <= {ppf_r, pidx_r, wpp_r, wcnt_r};
				`ATS_REG_RATE: reg_rdata <= {16'h0000, rate_r};
				`ATS_REG_ISTAT: reg_rdata <= {29'h00000000, ist_r};
				`ATS_REG_IEN: reg_rdata <= {29'h00000000, ien_r};
				`ATS_REG_EVT: reg_rdata <= evt_word;
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// Sticky status: a new event wins over a clear in the same cycle.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ist_r <= 3'h0;
		end else begin
			if (reg_wr && reg_addr == `ATS_REG_ICLR) begin
				ist_r <= (ist_r & ~reg_wdata[2:0]) |
					{cell_opp & susp & (st_r == ST_IDLE), frame_go, st_r == ST_DONE};
			end else begin
				ist_r <= ist_r |
					{cell_opp & susp & (st_r == ST_IDLE), frame_go, st_r == ST_DONE};
			end
		end
	end

	// ************************************************************
	// Segmentation engine.
	// ************************************************************

	// The software write of the packing word is for set-up only and wins.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			st_r <= ST_IDLE;
			ptr_r <= 32'h00000000;
			crc_r <= `ATS_CRC_INIT;
			wcnt_r <= 8'h00;
			pidx_r <= 8'h00;
			left_r <= 6'h00;
			close_r <= 1'b0;
			cell_start <= 1'b0;
			upd_ip <= 4'h0;
			gen_ip <= 4'h0;
			cell_type <= `ATS_T_RAW48;
			cell_hdr <= 32'h00000000;
			drop_sel <= 2'h0;
			pay_valid <= 1'b0;
			pay_data <= 32'h00000000;
			pay_bytes <= 3'h0;
		end else begin
			cell_start <= 1'b0;
			pay_valid <= 1'b0;
			if (frame_queue && st_r == ST_IDLE) begin
				ptr_r <= base_r + {16'h0000, cfg_r[`ATS_CFG_OFS_LO+15:`ATS_CFG_OFS_LO]}; // RL3 RL9
				crc_r <= `ATS_CRC_INIT;
			end else if (reg_wr && reg_addr == `ATS_REG_PTR) begin
				ptr_r <= reg_wdata;
			end
			if (ld_wr) begin
				wcnt_r <= reg_wdata[7:0];
				pidx_r <= reg_wdata[23:16];
			end
			case (st_r)
				ST_IDLE: begin
					// A suspended ABR channel lets the opportunity pass.
					if (cell_opp && ctrl_r[`ATS_CTRL_EN] && !susp) begin // RL1
						st_r <= ST_FETCH;
						cell_start <= 1'b1;
						upd_ip <= cfg_r[`ATS_CFG_ENTRY_LO+3:`ATS_CFG_ENTRY_LO]; // RL6
						gen_ip <= cfg_r[`ATS_CFG_ENTRY_LO+3:`ATS_CFG_ENTRY_LO]; // RL6
						cell_type <= ats_type(cfg_r[`ATS_CFG_ENTRY_LO+3:`ATS_CFG_ENTRY_LO]); // RL7
						left_r <= ats_pay(ats_type(cfg_r[`ATS_CFG_ENTRY_LO+3:`ATS_CFG_ENTRY_LO])); // RL7
						cell_hdr <= hdr_r; // RL8
						drop_sel <= cfg_r[`ATS_CFG_DROP_LO+1:`ATS_CFG_DROP_LO]; // RL2
						close_r <= 1'b0;
					end
				end
				ST_FETCH: begin
					if (fetch_ack) begin
						pay_valid <= 1'b1;
						pay_data <= fetch_data;
						pay_bytes <= take;
						ptr_r <= ptr_r + {29'h00000000, take}; // RL9
						crc_r <= crc_next; // RL10
						left_r <= left_r - {3'h0, take};
						close_r <= close_nxt;
						if (!ld_wr) begin
							wcnt_r <= wcnt_nxt; // RL11 RL16
							pidx_r <= pidx_nxt; // RL13 RL16
						end
						if (left_r <= `ATS_WORD_BYTES) begin
							st_r <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					// A closed frame restarts the CRC for the next one.
					if (close_r) begin
						crc_r <= `ATS_CRC_INIT;
					end
					st_r <= ST_IDLE;
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

endmodule

// file: tb/ats_seg_channel_properties.sv
// Purpose: Port assertions for the segmentation channel.
// Assumes: Bound to every ats_seg_channel instance.
// Notes: Register contents are judged by the bench, not here.
`timescale 1ns/10ps
module ats_seg_props #(
	parameter [31:0] DESC_ADDR = 32'h00000000
) (
	// Clock and reset.
	input wire core_clk,
	input wire rst_n,
	// Cell engine.
	input wire cell_opp,
	input wire cell_start,
	input wire [3:0] upd_ip,
	input wire [3:0] gen_ip,
	input wire [2:0] cell_type,
	input wire [1:0] drop_sel,
	input wire [3:0] drop_en,
	// Fetch, payload and events.
	input wire fetch_req,
	input wire [31:0] fetch_addr,
	input wire fetch_ack,
	input wire pay_valid,
	input wire evt_valid
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// An accepted opportunity: the pulse, then the start one cycle on.
	sequence s_accept;
		cell_opp ##1 cell_start;
	endsequence
	// One answered fetch word.
	sequence s_word;
		fetch_req && fetch_ack;
	endsequence
	a_drop_onehot: assert property (drop_en == (4'h1 << drop_sel))
		else $error("drop enable is not the decode of the select");
	a_accept_fetch: assert property (s_accept |-> fetch_req)
		else $error("fetch did not begin with the cell");
	a_start_cause: assert property (cell_start |-> $past(cell_opp))
		else $error("cell start without an opportunity");
	a_ip_both: assert property (cell_start |-> upd_ip == gen_ip)
		else $error("processor pointers differ");
	a_start_pulse: assert property (cell_start |=> !cell_start)
		else $error("cell start longer than one cycle");
	a_type_hold: assert property (cell_start |=> ($stable(cell_type) && $stable(gen_ip))[*4])
		else $error("cell type moved inside a cell");
	a_addr_hold: assert property ((fetch_req && !fetch_ack) |=> $stable(fetch_addr))
		else $error("pointer moved without a fetch answer");
	a_pay_word: assert property (pay_valid == $past(fetch_req && fetch_ack))
		else $error("payload word not tied to a fetch answer");
	a_word_pay: assert property (s_word |=> pay_valid)
		else $error("answered fetch word gave no payload");
	a_evt_pulse: assert property (evt_valid |=> !evt_valid)
		else $error("event valid longer than one cycle");
endmodule

bind ats_seg_channel ats_seg_props #(.DESC_ADDR(DESC_ADDR)) u_props (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.cell_opp(cell_opp),
	.cell_start(cell_start),
	.upd_ip(upd_ip),
	.gen_ip(gen_ip),
	.cell_type(cell_type),
	.drop_sel(drop_sel),
	.drop_en(drop_en),
	.fetch_req(fetch_req),
	.fetch_addr(fetch_addr),
	.fetch_ack(fetch_ack),
	.pay_valid(pay_valid),
	.evt_valid(evt_valid)
);

// file: tb/ats_fetch_model.sv
// Purpose: Buffer memory answering the channel's fetch port.
// Assumes: One word per request, answered from flip-flops.
// Notes: Data is the address scrambled, so every word differs.
`timescale 1ns/10ps
module ats_fetch_model (
	// Clock and reset.
	input wire core_clk,
	input wire rst_n,
	// Fetch port.
	input wire fetch_req,
	input wire [31:0] fetch_addr,
	output reg fetch_ack,
	output reg [31:0] fetch_data,
	output reg fetch_last,
	// Pace and the address that ends a frame.
	input wire slow,
	input wire [31:0] last_addr
);
	reg [1:0] gap_r; // Idle cycles still owed before the next answer.
	// A slow memory waits three cycles between words, a fast one one. Between answers
	// the data bus toggles each cycle between the inverse of the last word and the word.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			fetch_ack <= 1'b0;
			fetch_data <= 32'h00000000;
			fetch_last <= 1'b0;
			gap_r <= 2'h0;
		end else if (fetch_req && !fetch_ack && gap_r == 2'h0) begin
			fetch_ack <= 1'b1;
			fetch_data <= fetch_addr ^ 32'h5A5A0000;
			fetch_last <= (fetch_addr == last_addr);
			gap_r <= slow ? 2'h2 : 2'h0;
		end else begin
			fetch_ack <= 1'b0;
			fetch_data <= ~fetch_data;
			fetch_last <= 1'b0;
			if (fetch_req && !fetch_ack)
				gap_r <= gap_r - 2'h1;
		end
	end
endmodule

// file: tb/tb.sv
// Purpose: Self-checking bench of the segmentation channel.
// Assumes: 20 MHz clock, synchronous active-low reset.
// Notes: Each scenario drives the block and judges it before returning.
`timescale 1ns/10ps
`include "ats_defines.vh"
module tb;
	reg core_clk = 1'b0;
	reg rst_n = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h00000000;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg cell_opp = 1'b0;
	reg frame_queue = 1'b0;
	reg slow = 1'b0;
	reg [31:0] last_addr = 32'hFFFFFFFF;
	wire [31:0] reg_rdata, cell_hdr, fetch_addr, fetch_data, pay_data, evt_word;
	wire [3:0] upd_ip, gen_ip, drop_en;
	wire [2:0] cell_type, pay_bytes;
	wire [1:0] drop_sel;
	wire [15:0] abr_rate;
	wire cell_start, fetch_req, fetch_ack, fetch_last, pay_valid, evt_valid, irq;
	integer fail_count = 0;
	integer samples_checked = 0;
	integer n_start, n_pay, n_evt;
	reg [31:0] cap_hdr, cap_evt, rv, e;
	reg [31:0] cap_pd;
	reg [7:0] cap_ip;
	reg [5:0] cap_drop;
	reg [2:0] cap_type, cap_pb;
	int nbytes [0:6] = '{48, 52, 48, 48, 54, 48, 48};
	int nwords [0:6] = '{12, 13, 12, 12, 14, 12, 12};
	int ctl [0:2] = '{7, 5, 3};
	reg [31:0] evx [0:2] = '{32'h00002180, 32'h00002000, 32'h00000400};

	always #25 core_clk = ~core_clk;

	ats_seg_channel #(.DESC_ADDR(32'h00000400)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cell_opp(cell_opp), .frame_queue(frame_queue),
		.cell_start(cell_start), .upd_ip(upd_ip), .gen_ip(gen_ip), .cell_type(cell_type),
		.cell_hdr(cell_hdr), .drop_sel(drop_sel), .drop_en(drop_en), .abr_rate(abr_rate),
		.fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
		.fetch_data(fetch_data), .fetch_last(fetch_last), .pay_valid(pay_valid),
		.pay_data(pay_data), .pay_bytes(pay_bytes), .evt_valid(evt_valid),
		.evt_word(evt_word), .irq(irq));
	ats_fetch_model u_mem (.core_clk(core_clk), .rst_n(rst_n), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
		.fetch_last(fetch_last), .slow(slow), .last_addr(last_addr));

	// Compares one value and counts it; a mismatch is reported at once.
	task chk(input string nm, input [31:0] x, input [31:0] g);
		samples_checked++;
		if (g !== x) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, x, g);
		end
	endtask
	// Reference CRC step over one word, most significant data bit first.
	function [31:0] crc_step(input [31:0] c, input [31:0] d);
		integer k;
		crc_step = c;
		for (k = 31; k >= 0; k--)
			crc_step = {crc_step[30:0], 1'b0} ^ ((crc_step[31] ^ d[k]) ? `ATS_CRC_POLY : 32'h0);
	endfunction
	task wr(input [7:0] a, input [31:0] d);
		@(posedge core_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
		@(posedge core_clk) reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task rd(input [7:0] a, output [31:0] d);
		@(posedge core_clk) begin reg_addr <= a; reg_rd <= 1'b1; end
		@(posedge core_clk) reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task queue_frame;
		@(posedge core_clk) frame_queue <= 1'b1;
		@(posedge core_clk) frame_queue <= 1'b0;
	endtask
	// Offers one opportunity and watches 80 cycles, long enough for a slow cell.
	task run_cell;
		integer i;
		n_start = 0;
		n_pay = 0;
		n_evt = 0;
		@(posedge core_clk) cell_opp <= 1'b1;
		@(posedge core_clk) cell_opp <= 1'b0;
		for (i = 0; i < 80; i++) begin
			#1;
			if (cell_start) begin
				n_start++;
				cap_ip = {upd_ip, gen_ip};
				cap_type = cell_type;
				cap_hdr = cell_hdr;
				cap_drop = {drop_sel, drop_en};
			end
			if (pay_valid) begin
				n_pay++;
				cap_pd = pay_data;
				cap_pb = pay_bytes;
			end
			if (evt_valid) begin
				n_evt++;
				cap_evt = evt_word;
			end
			@(posedge core_clk);
		end
	endtask

	// ************************************************************
	// Scenarios.
	// ************************************************************
	task t_reset;
		rd(`ATS_REG_PACK, rv);
		chk("pack", 32'h01002F00, rv);
		rd(`ATS_REG_CRC, rv);
		chk("crc", 32'hFFFFFFFF, rv);
		rd(`ATS_REG_CFG, rv);
		chk("cfg", 32'h00000000, rv);
		rd(8'h30, rv);
		chk("unmapped", 32'h00000000, rv);
	endtask
	// Entry points 0 to 6 once each, with drop, header and pace varied.
	task t_types;
		integer k;
		reg [31:0] e_crc;
		wr(`ATS_REG_BASE, 32'h00001000);
		wr(`ATS_REG_RATE, 32'h00001234);
		wr(`ATS_REG_CTRL, 32'h00000001);
		for (e = 0; e < 7; e++) begin
			wr(`ATS_REG_CFG, 32'h00001000 | (e << 4) | ((e % 4) << 2));
			slow <= e[0];
			wr(`ATS_REG_HDR, 32'hC0DE0000 | e);
			queue_frame();
			rd(`ATS_REG_PTR, rv);
			chk("start ptr", 32'h00001010, rv);
			rd(`ATS_REG_CRC, rv);
			chk("crc init", 32'hFFFFFFFF, rv);
			run_cell();
			chk("ips", {24'h0, e[3:0], e[3:0]}, {24'h0, cap_ip});
			chk("type", (e < 6) ? e : 32'h0, {29'h0, cap_type});
			chk("hdr", 32'hC0DE0000 | e, cap_hdr);
			chk("drop", {26'h0, e[1:0], 4'h1 << e[1:0]}, {26'h0, cap_drop});
			chk("words", nwords[e], n_pay);
			rd(`ATS_REG_PTR, rv);
			chk("end ptr", 32'h00001010 + nbytes[e], rv);
			chk("rate", 32'h00001234, {16'h0, abr_rate});
			// No frame closes here, so the CRC spans every word of the cell.
			e_crc = `ATS_CRC_INIT;
			for (k = 0; k < nwords[e]; k++)
				e_crc = crc_step(e_crc, (32'h00001010 + 4 * k) ^ 32'h5A5A0000);
			rd(`ATS_REG_CRC, rv);
			chk("run crc", e_crc, rv);
			chk("last word", (32'h00001010 + 4 * (nwords[e] - 1)) ^ 32'h5A5A0000, cap_pd);
			chk("last bytes", nbytes[e] - 4 * (nwords[e] - 1), {29'h0, cap_pb});
		end
		#1 chk("irq masked", 32'h0, {31'h0, irq});
		rd(`ATS_REG_ISTAT, rv);
		chk("cell done", 32'h1, rv & 32'h1);
		wr(`ATS_REG_IEN, 32'h00000007);
		#1 chk("irq raised", 32'h1, {31'h0, irq});
		wr(`ATS_REG_ICLR, 32'h00000007);
		#1 chk("irq cleared", 32'h0, {31'h0, irq});
	endtask
	// Suspend holds ABR cells only.
	task t_susp;
		wr(`ATS_REG_CFG, 32'h00000003);
		run_cell();
		chk("susp abr", 32'h0, n_start);
		rd(`ATS_REG_ISTAT, rv);
		chk("skip flag", 32'h4, rv & 32'h4);
		wr(`ATS_REG_CFG, 32'h00000001);
		run_cell();
		chk("susp plain", 32'h1, n_start);
		wr(`ATS_REG_ICLR, 32'h00000007);
	endtask
	// Modifier in buffer events, with and without enable, and in descriptor events.
	task t_events;
		integer m;
		wr(`ATS_REG_BASE, 32'h00002000);
		last_addr <= 32'h00002000;
		for (m = 0; m < 3; m++) begin
			wr(`ATS_REG_CTRL, ctl[m]);
			wr(`ATS_REG_CFG, 32'h03000000);
			queue_frame();
			run_cell();
			chk("evt count", 32'h1, n_evt);
			chk("evt word", evx[m], cap_evt);
		end
		last_addr <= 32'hFFFFFFFF;
	endtask
	// Short packets: twelve words of four-word packets, two packets a frame.
	task t_frame;
		wr(`ATS_REG_CTRL, 32'h00000001);
		wr(`ATS_REG_PACK, 32'h02000400);
		wr(`ATS_REG_CFG, 32'h00000050);
		queue_frame();
		run_cell();
		chk("frame close", 32'h1, n_evt);
		rd(`ATS_REG_PACK, rv);
		chk("word count", 32'h0, rv & 32'hFF);
		chk("sizes", 32'h02000400, rv & 32'hFF00FF00);
		chk("packet index", 32'h00010000, rv & 32'h00FF0000);
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_types();
		t_susp();
		t_events();
		t_frame();
		complete_run();
	end
	// The scenarios need about 1200 cycles; this cuts a hang short.
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		complete_run();
	end
endmodule
